// ### shared/card_if_defines.svh
`ifndef CARD_IF_DEFINES_SVH
`define CARD_IF_DEFINES_SVH

// Clock period in ns (20 MHz)
`define CLK_PERIOD_NS      50
// Supply must stay good this long before ready is raised, in ns
`define SUPPLY_SETTLE_NS   20000
// Least time, rounded up to whole cycles
`define SUPPLY_SETTLE_CYC  ((`SUPPLY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W       10
// Number of data line pairs: data, aux 1, aux 2
`define LINE_PAIRS         3
// Supply select codes
`define VSEL_OFF           2'h0
`define VSEL_LOW           2'h1
`define VSEL_MID           2'h2
`define VSEL_HIGH          2'h3

`endif

// ### shared/card_if_pkg.sv
package card_if_pkg;

    typedef enum logic [3:0] {
        SEQ_IDLE   = 4'b0001,
        SEQ_RAMP   = 4'b0010,
        SEQ_ACTIVE = 4'b0100,
        SEQ_DEACT  = 4'b1000
    } seq_state_t;

    typedef enum logic [2:0] {
        DIR_NEUTRAL  = 3'b001,
        DIR_HOST_IN  = 3'b010,
        DIR_CARD_IN  = 3'b100
    } dir_state_t;

endpackage

// ### logic/line_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two flop synchroniser for a vector of pin inputs
module line_sync #(
    parameter int W   = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule
`default_nettype wire

// ### logic/line_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
`include "card_if_defines.svh"
// Direction arbitration for one host/card line pair
module line_arbiter (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic rx_en_i,
    input  wire logic pass_en_i,
    // Synchronised line levels
    input  wire logic host_in_i,
    input  wire logic card_in_i,
    // Drives, open-drain style: enable pulls low; then the two direction flags
    output logic      host_drive_low_o,
    output logic      card_drive_low_o,
    output logic      card_idle_low_o,
    output logic      host_is_input_o,
    output logic      card_is_input_o
);

    card_if_pkg::dir_state_t state_ff;
    card_if_pkg::dir_state_t nxt_state;
    logic host_prev_ff;
    logic card_prev_ff;
    logic host_ff;
    logic card_ff;

    wire host_fall = host_prev_ff & ~host_in_i;
    wire card_fall = card_prev_ff & ~card_in_i;
    wire host_rise = ~host_prev_ff & host_in_i;
    wire card_rise = ~card_prev_ff & card_in_i;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            card_if_pkg::DIR_NEUTRAL: begin
                // Host wins a same-cycle tie; host is the expected talker
                if (!rx_en_i) nxt_state = card_if_pkg::DIR_NEUTRAL;
                else if (host_fall) nxt_state = card_if_pkg::DIR_HOST_IN;
                else if (card_fall) nxt_state = card_if_pkg::DIR_CARD_IN;
            end
            card_if_pkg::DIR_HOST_IN: begin
                if (!rx_en_i || host_rise) nxt_state = card_if_pkg::DIR_NEUTRAL;
            end
            card_if_pkg::DIR_CARD_IN: begin
                if (!rx_en_i || card_rise) nxt_state = card_if_pkg::DIR_NEUTRAL;
            end
            default: nxt_state = card_if_pkg::DIR_NEUTRAL;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff     <= card_if_pkg::DIR_NEUTRAL;
            host_prev_ff <= 1'b1;
            card_prev_ff <= 1'b1;
            host_ff      <= 1'b0;
            card_ff      <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            host_prev_ff <= host_in_i;
            card_prev_ff <= card_in_i;
            // Mirror the input side onto the output side
            host_ff      <= pass_en_i && nxt_state == card_if_pkg::DIR_CARD_IN && !card_in_i;
            card_ff      <= pass_en_i && nxt_state == card_if_pkg::DIR_HOST_IN && !host_in_i;
        end
    end

    assign host_drive_low_o = host_ff;
    assign card_drive_low_o = card_ff;
    assign card_idle_low_o  = ~rx_en_i;
    assign host_is_input_o  = state_ff == card_if_pkg::DIR_HOST_IN;
    assign card_is_input_o  = state_ff == card_if_pkg::DIR_CARD_IN;

endmodule
`default_nettype wire

// ### logic/card_interface_select_fault_io.sv
// Notes on behaviour
// - Idle with supplies off, status mirrors card presence.
// - Idle: no fault checks, no deactivation.
// - In ramp or active, extraction or fault drives status low.
// - Status low in session starts deactivation immediately.
// - Chip select high: host inputs steer directly.
// - Activated and selected: data pairs pass through.
// - Chip select fall latches host control inputs.
// - Chip select low blocks all data transfer.
// - Chip select low floats status and ready.
// - Fault and presence sensing ignore chip select.
// - Card lines low until reception is enabled.
// - Host data and aux lines high after reset.
// - First falling side becomes input, other driven.
// - Rising edge on input returns pair neutral.
// - Supply command low ramps; both low selects lowest.
// - Ready rises after supply good for 20 us.
// - Over-current and extraction force deactivation; under-voltage only once ready.
`timescale 1ns/10ps
`default_nettype none
`include "card_if_defines.svh"
module card_interface_select_fault_io (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Host control pins
    input  wire logic       chip_select_i,
    input  wire logic       supply_cmd_mid_n_i,
    input  wire logic       supply_cmd_high_n_i,
    input  wire logic       host_card_reset_in_i,
    input  wire logic       host_card_clock_in_i,
    // Card and supply sensing
    input  wire logic       card_presence_in_i,
    input  wire logic       supply_ok_i,
    input  wire logic       over_current_i,
    input  wire logic       deact_done_i,
    // Host-side two-way lines: data, aux 1, aux 2
    input  wire logic [2:0] host_line_i,
    output logic      [2:0] host_line_o,
    output logic      [2:0] host_line_oe_o,
    // Card-side two-way lines: data, aux 1, aux 2
    input  wire logic [2:0] card_line_i,
    output logic      [2:0] card_line_o,
    output logic      [2:0] card_line_oe_o,
    // Status open-drain outputs
    output logic            card_status_o,
    output logic            card_status_oe_o,
    output logic            supply_good_o,
    output logic            supply_good_oe_o,
    // Card control and supply
    output logic            card_reset_o,
    output logic            card_clock_o,
    output logic      [1:0] supply_select_o,
    output logic            deactivating_o
);

    localparam int SETTLE_CYC = `SUPPLY_SETTLE_CYC;

    // Synchronised pins
    logic [7:0] sync_bus;
    logic [2:0] host_s;
    logic [2:0] card_s;
    line_sync #(.W(8), .INIT(8'h0E)) u_ctl_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({over_current_i, supply_ok_i, card_presence_in_i, host_card_clock_in_i,
                   host_card_reset_in_i, supply_cmd_high_n_i, supply_cmd_mid_n_i, chip_select_i}),
        .sync_o  (sync_bus)
    );
    line_sync #(.W(6), .INIT(6'h3F)) u_line_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({card_line_i, host_line_i}),
        .sync_o  ({card_s, host_s})
    );

    wire cs_s    = sync_bus[0];
    wire mid_s   = sync_bus[1];
    wire high_s  = sync_bus[2];
    wire rst_s   = sync_bus[3];
    wire clk_s   = sync_bus[4];
    wire card_presence_in_s  = sync_bus[5];
    wire vok_s   = sync_bus[6];
    wire oc_s    = sync_bus[7];

    // Held host controls while deselected
    logic       mid_hold_ff;
    logic       high_hold_ff;
    logic       rst_hold_ff;
    logic       clk_hold_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mid_hold_ff  <= 1'b1;
            high_hold_ff <= 1'b1;
            rst_hold_ff  <= 1'b0;
            clk_hold_ff  <= 1'b0;
        end else if (cs_s) begin
            mid_hold_ff  <= mid_s;
            high_hold_ff <= high_s;
            rst_hold_ff  <= rst_s;
            clk_hold_ff  <= clk_s;
        end
    end

    // Effective host controls: live when selected, frozen otherwise
    wire mid_eff  = cs_s ? mid_s  : mid_hold_ff;
    wire high_eff = cs_s ? high_s : high_hold_ff;
    wire rst_eff  = cs_s ? rst_s  : rst_hold_ff;
    wire clk_eff  = cs_s ? clk_s  : clk_hold_ff;
    wire session_req = ~mid_eff | ~high_eff;

    // Session sequencer
    card_if_pkg::seq_state_t seq_ff;
    card_if_pkg::seq_state_t nxt_seq;
    logic [`SETTLE_CNT_W-1:0] settle_ff;
    logic                     ready_ff;
    logic                     fault_ff;
    logic [1:0]               vsel_ff;
    logic [1:0]               nxt_vsel;

    // Fault sensing works whatever chip select does
    wire fault_now = ~card_presence_in_s | oc_s | (ready_ff & ~vok_s);
    wire in_session = seq_ff != card_if_pkg::SEQ_IDLE;
    wire fault_trip = in_session && seq_ff != card_if_pkg::SEQ_DEACT && fault_now;
    wire settle_done = settle_ff == `SETTLE_CNT_W'(SETTLE_CYC - 1);

    // Both low selects the lowest supply; later single edges are not re-evaluated
    assign nxt_vsel = (~mid_eff & ~high_eff) ? `VSEL_LOW :
                      (~high_eff)            ? `VSEL_HIGH :
                      (~mid_eff)             ? `VSEL_MID : `VSEL_OFF;

    always_comb begin
        nxt_seq = seq_ff;
        case (seq_ff)
            card_if_pkg::SEQ_IDLE: begin
                // Idle never reacts to faults, only to a request with a card present
                if (session_req && card_presence_in_s) nxt_seq = card_if_pkg::SEQ_RAMP;
            end
            card_if_pkg::SEQ_RAMP: begin
                if (fault_trip || !session_req) nxt_seq = card_if_pkg::SEQ_DEACT;
                else if (vok_s && settle_done) nxt_seq = card_if_pkg::SEQ_ACTIVE;
            end
            card_if_pkg::SEQ_ACTIVE: begin
                if (fault_trip || !session_req) nxt_seq = card_if_pkg::SEQ_DEACT;
            end
            card_if_pkg::SEQ_DEACT: begin
                if (deact_done_i && !session_req) nxt_seq = card_if_pkg::SEQ_IDLE;
            end
            default: nxt_seq = card_if_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_ff    <= card_if_pkg::SEQ_IDLE;
            settle_ff <= '0;
            ready_ff  <= 1'b0;
            fault_ff  <= 1'b0;
            vsel_ff   <= `VSEL_OFF;
        end else begin
            seq_ff <= nxt_seq;
            if (seq_ff == card_if_pkg::SEQ_RAMP && vok_s && !settle_done)
                settle_ff <= settle_ff + `SETTLE_CNT_W'(1);
            else if (seq_ff != card_if_pkg::SEQ_RAMP || !vok_s)
                settle_ff <= '0;
            ready_ff <= nxt_seq == card_if_pkg::SEQ_ACTIVE;
            // Fault flag is set the cycle deactivation begins
            if (fault_trip) fault_ff <= 1'b1;
            else if (nxt_seq == card_if_pkg::SEQ_IDLE) fault_ff <= 1'b0;
            if (seq_ff == card_if_pkg::SEQ_IDLE) vsel_ff <= nxt_vsel;
            else if (nxt_seq == card_if_pkg::SEQ_IDLE) vsel_ff <= `VSEL_OFF;
        end
    end

    // Status level: presence when idle, fault indicator in session
    wire status_lvl = in_session ? ~(fault_ff | fault_trip) : card_presence_in_s;

    // Status outputs: open drain, released whenever deselected
    logic status_low_ff;
    logic ready_low_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_low_ff <= 1'b0;
            ready_low_ff  <= 1'b0;
        end else begin
            status_low_ff <= ~status_lvl;
            ready_low_ff  <= ~ready_ff;
        end
    end
    assign card_status_o    = 1'b0;
    assign card_status_oe_o = cs_s & status_low_ff;
    assign supply_good_o    = 1'b0;
    assign supply_good_oe_o = cs_s & ready_low_ff;

    // Card control: held low outside the active state
    wire active = seq_ff == card_if_pkg::SEQ_ACTIVE;
    logic card_reset_ff;
    logic card_clock_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            card_reset_ff <= 1'b0;
            card_clock_ff <= 1'b0;
        end else begin
            card_reset_ff <= active & rst_eff;
            card_clock_ff <= active & clk_eff;
        end
    end
    assign card_reset_o    = card_reset_ff;
    assign card_clock_o    = card_clock_ff;
    assign supply_select_o = vsel_ff;
    assign deactivating_o  = seq_ff == card_if_pkg::SEQ_DEACT;

    // Per-pair direction arbitration
    wire [2:0] host_dl;
    wire [2:0] card_dl;
    wire [2:0] card_idle;
    genvar gi;
    generate
        for (gi = 0; gi < `LINE_PAIRS; gi = gi + 1) begin : g_pair
            line_arbiter u_arb (
                .clk_i            (clk_i),
                .rst_i            (rst_i),
                .rx_en_i          (active),
                .pass_en_i        (cs_s),
                .host_in_i        (host_s[gi]),
                .card_in_i        (card_s[gi]),
                .host_drive_low_o (host_dl[gi]),
                .card_drive_low_o (card_dl[gi]),
                .card_idle_low_o  (card_idle[gi]),
                .host_is_input_o  (),
                .card_is_input_o  ()
            );
        end
    endgenerate

    // Host lines idle released (pulled high), card lines held low when off
    assign host_line_o    = 3'h0;
    assign host_line_oe_o = host_dl;
    assign card_line_o    = 3'h0;
    assign card_line_oe_o = card_dl | card_idle;

    AST_IDLE_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
        (!in_session && cs_s && $stable(card_presence_in_s)) |=> (status_low_ff == ~$past(card_presence_in_s)))
        else $error("status does not follow presence when idle");
    AST_IDLE_NO_DEACT: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_ff == card_if_pkg::SEQ_IDLE) |=> (seq_ff != card_if_pkg::SEQ_DEACT))
        else $error("deactivation from idle");
    AST_FAULT_DEACT: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_trip |=> (seq_ff == card_if_pkg::SEQ_DEACT) && status_low_ff)
        else $error("fault did not start deactivation");
    AST_CS_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
        !cs_s |-> !card_status_oe_o && !supply_good_oe_o)
        else $error("status driven while deselected");
    AST_CS_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cs_s ##1 !cs_s) |-> (host_dl == 3'h0) && (card_dl == 3'h0))
        else $error("data passed while deselected");
    AST_CS_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cs_s && !$past(cs_s)) |-> $stable(mid_hold_ff) && $stable(rst_hold_ff))
        else $error("held controls changed while deselected");
    AST_CARD_LOW_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !active |-> (card_line_oe_o == 3'h7))
        else $error("card lines not held low");
    AST_READY_SETTLE: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ready_ff) |-> settle_ff == `SETTLE_CNT_W'(SETTLE_CYC - 1))
        else $error("ready before settle time");
    AST_BOTH_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_ff == card_if_pkg::SEQ_IDLE && !mid_eff && !high_eff) |=> vsel_ff == `VSEL_LOW)
        else $error("both commands did not select lowest supply");

    COV_ACTIVATE: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ready_ff));
    COV_FAULT: cover property (@(posedge clk_i) disable iff (rst_i) fault_trip && active);
    COV_DESELECT: cover property (@(posedge clk_i) disable iff (rst_i) $fell(cs_s) && active);
    COV_PASS: cover property (@(posedge clk_i) disable iff (rst_i) |card_dl);

endmodule
`default_nettype wire

// ### test/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host controller stand-in: open-drain pulls on data, aux 1 and aux 2
module host_model (
    // Clock
    input  wire logic       clk_i,
    // Observed state
    input  wire logic       session_i,
    input  wire logic       card_status_i,
    // Line pulls, high pulls the host line low
    output logic      [2:0] host_pull_o
);
    logic halted;

    initial begin
        host_pull_o = 3'h0;
        halted = 1'b0;
    end

    // Sticky until the session ends, so a late glitch cannot restart traffic
    always @(negedge clk_i) begin
        halted <= session_i & (halted | ~card_status_i);
    end

    task automatic pull(input int idx, input logic lvl);
        @(negedge clk_i);
        if (!halted) begin
            host_pull_o[idx] = lvl;
        end
    endtask
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "card_if_defines.svh"
module tb;
    logic        clk_i, rst_i, chip_select_i, cmd_mid_n, cmd_high_n, rst_in, clk_in;
    logic        presence, supply_ok, over_current, deact_done, session;
    logic [2:0]  card_pull, host_pull, host_line_o, host_line_oe_o, card_line_o, card_line_oe_o;
    logic        card_status_o, card_status_oe_o, supply_good_o, supply_good_oe_o;
    logic        card_reset_o, card_clock_o, deactivating_o;
    logic [1:0]  supply_select_o;
    logic [7:0]  aux, mon_got;
    logic [7:0]  exp_q[$];
    logic [31:0] rng;
    int          sel_q[$];
    int          fail_count, tests_run, waited;
    // Pull-ups on every two-way line and on the status line
    wire  [2:0]  host_wire = ~(host_line_oe_o & ~host_line_o) & ~host_pull;
    wire  [2:0]  card_wire = ~(card_line_oe_o & ~card_line_o) & ~card_pull;
    wire         status_wire = ~(card_status_oe_o & ~card_status_o);

    card_interface_select_fault_io u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .chip_select_i(chip_select_i),
        .supply_cmd_mid_n_i(cmd_mid_n), .supply_cmd_high_n_i(cmd_high_n),
        .host_card_reset_in_i(rst_in), .host_card_clock_in_i(clk_in),
        .card_presence_in_i(presence), .supply_ok_i(supply_ok), .over_current_i(over_current),
        .deact_done_i(deact_done), .host_line_i(host_wire), .host_line_o(host_line_o),
        .host_line_oe_o(host_line_oe_o), .card_line_i(card_wire), .card_line_o(card_line_o),
        .card_line_oe_o(card_line_oe_o), .card_status_o(card_status_o),
        .card_status_oe_o(card_status_oe_o), .supply_good_o(supply_good_o),
        .supply_good_oe_o(supply_good_oe_o), .card_reset_o(card_reset_o),
        .card_clock_o(card_clock_o), .supply_select_o(supply_select_o),
        .deactivating_o(deactivating_o)
    );

    host_model u_host (
        .clk_i(clk_i), .session_i(session), .card_status_i(status_wire), .host_pull_o(host_pull)
    );

    always #25 clk_i = ~clk_i;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    function automatic logic [7:0] obs(input int sel);
        case (sel)
            0: return {7'h00, card_status_oe_o & ~card_status_o};
            1: return {7'h00, supply_good_oe_o & ~supply_good_o};
            2: return {5'h00, host_line_oe_o};
            3: return {5'h00, card_line_oe_o};
            4: return {7'h00, deactivating_o};
            5: return {6'h00, supply_select_o};
            6: return {6'h00, card_clock_o, card_reset_o};
            default: return aux;
        endcase
    endfunction

    task automatic note(input int sel, input logic [7:0] exp);
        sel_q.push_back(sel);
        exp_q.push_back(exp);
    endtask

    // Outputs only move at rising edges, so a falling edge plus a step is settled
    always @(negedge clk_i) begin
        #1;
        while (sel_q.size() > 0) begin
            mon_got = obs(sel_q.pop_front());
            tests_run++;
            if (mon_got !== exp_q[0]) begin
                fail_count++;
                $display("unexpected at %0t: expected %h got %h", $time, exp_q[0], mon_got);
            end
            void'(exp_q.pop_front());
        end
    end

    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic do_reset();
        @(negedge clk_i);
        rst_i = 1'b1;
        step(20);
        rst_i = 1'b0;
        step(3);
    endtask

    task automatic wait_for(input int sel, input logic [7:0] val, input int lim);
        waited = 0;
        while (obs(sel) !== val && waited < lim) begin
            step(1);
            waited++;
        end
    endtask

    task automatic start_session(input logic mid_n, input logic high_n);
        // Commands released first, so a left-over low cannot start the session early
        cmd_mid_n = 1'b1;
        cmd_high_n = 1'b1;
        presence = 1'b1;
        supply_ok = 1'b1;
        chip_select_i = 1'b1;
        rst_in = 1'b0;
        clk_in = 1'b0;
        step(6);
        cmd_mid_n = mid_n;
        cmd_high_n = high_n;
        session = 1'b1;
        wait_for(1, 8'h00, 700);
        aux = {7'h00, waited >= 400};
        note(7, 8'h01);
        wait_for(3, 8'h00, 50);
        note(3, 8'h00);
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        fail_count++;
        complete_run();
    end

    initial begin
        {clk_i, chip_select_i, rst_in, clk_in, presence, supply_ok, over_current} = 7'h00;
        {rst_i, cmd_mid_n, cmd_high_n} = 3'h7;
        {deact_done, session, card_pull, aux} = 13'h0000;
        {fail_count, tests_run, waited} = {32'h0, 32'h0, 32'h0};
        rng = 32'h0000FE67;
        do_reset();
        note(3, 8'h07);
        note(2, 8'h00);
        note(0, 8'h00);
        chip_select_i = 1'b1;
        step(6);
        note(0, 8'h01);
        presence = 1'b1;
        over_current = 1'b1;
        step(6);
        note(0, 8'h00);
        note(4, 8'h00);
        over_current = 1'b0;
        start_session(1'b0, 1'b1);
        note(5, {6'h00, `VSEL_MID});
        for (int i = 0; i < 3; i++) begin
            u_host.pull(i, 1'b1);
            step(5);
            note(3, 8'h01 << i);
            u_host.pull(i, 1'b0);
            step(6);
            note(3, 8'h00);
            card_pull[i] = 1'b1;
            step(5);
            note(2, 8'h01 << i);
            card_pull[i] = 1'b0;
            step(6);
            note(2, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            rst_in = rng[0];
            clk_in = rng[1];
            step(5);
            note(6, {6'h00, rng[1:0]});
        end
        // Deselected: the host pin changes below must not reach the card; card removal still deactivates
        chip_select_i = 1'b0;
        step(5);
        rst_in = ~rng[0];
        clk_in = ~rng[1];
        cmd_mid_n = 1'b1;
        step(6);
        note(6, {6'h00, rng[1:0]});
        note(4, 8'h00);
        note(0, 8'h00);
        note(1, 8'h00);
        u_host.pull(0, 1'b1);
        step(5);
        note(3, 8'h00);
        u_host.pull(0, 1'b0);
        presence = 1'b0;
        step(6);
        note(4, 8'h01);
        cmd_mid_n = 1'b0;
        chip_select_i = 1'b1;
        step(6);
        note(0, 8'h01);
        session = 1'b0;
        do_reset();
        start_session(1'b0, 1'b0);
        note(5, {6'h00, `VSEL_LOW});
        over_current = 1'b1;
        wait_for(0, 8'h01, 20);
        note(4, 8'h01);
        over_current = 1'b0;
        deact_done = 1'b1;
        cmd_mid_n = 1'b1;
        cmd_high_n = 1'b1;
        session = 1'b0;
        wait_for(4, 8'h00, 50);
        step(6);
        note(3, 8'h07);
        note(0, 8'h00);
        step(2);
        complete_run();
    end
endmodule
`default_nettype wire
